// ### verilog/vimu_defines.vh
`ifndef VIMU_DEFINES_VH
`define VIMU_DEFINES_VH
// ****************************************
// Lane counts and widths
// ****************************************
`define VIMU_NUM_INT 4
`define VIMU_NUM_MUL 2
`define VIMU_DW 32
`define VIMU_OPW 4
`define VIMU_FWDW 3
// ****************************************
// Timing in cycles: issue-to-retire delay common to every operation, and integer bypass delay
// ****************************************
`define VIMU_RETIRE_LAT 3
`define VIMU_INT_LAT 1
// ****************************************
// Integer operation codes
// ****************************************
`define VIMU_OP_ADD 4'h0
`define VIMU_OP_SUB 4'h1
`define VIMU_OP_AND 4'h2
`define VIMU_OP_OR 4'h3
`define VIMU_OP_XOR 4'h4
`define VIMU_OP_SHL 4'h5
`define VIMU_OP_SHR 4'h6
`define VIMU_OP_SHRU 4'h7
`define VIMU_OP_CMPEQ 4'h8
`define VIMU_OP_CMPLT 4'h9
`define VIMU_OP_CMPLTU 4'hA
`define VIMU_OP_SLCT 4'hB
`define VIMU_OP_MIN 4'hC
`define VIMU_OP_MAX 4'hD
`define VIMU_OP_ANDC 4'hE
`define VIMU_OP_NOP 4'hF
// ****************************************
// Multiply operation codes
// ****************************************
`define VIMU_MOP_MULL 4'h0
`define VIMU_MOP_MULH 4'h1
`define VIMU_MOP_MULHU 4'h2
// ****************************************
// Forward select: 0 takes the issued operand, k+1 takes integer lane k
// ****************************************
`define VIMU_FWD_NONE 3'h0
// ****************************************
// Reset values
// ****************************************
`define VIMU_RST_WORD 32'h00000000
`define VIMU_RST_BIT 1'h0
`endif

// ### verilog/vimu_datapath.v
// Function
// - Four integer lanes, two multiply lanes, parallel
// - Integer result usable by very next bundle
// - Integer inputs: two words, one condition
// - Integer outputs: one word, one condition
// - Multiply is three-stage, accepts every cycle
// - Multiply: two word sources, one word
// - Whole bundle dispatched same cycle, no regrouping
// - Bundle retires together, one fixed delay
// - Integer results bypassed before formal retire
`timescale 1ns/100ps
`include "vimu_defines.vh"

module vimu_datapath #(
  parameter NI = `VIMU_NUM_INT,
  parameter NM = `VIMU_NUM_MUL,
  parameter DW = `VIMU_DW
) (
  input wire I_CLK,
  input wire I_RST,
  input wire [NI-1:0] i_INT_VLD,
  input wire [NI*4-1:0] i_INT_OP,
  input wire [NI*DW-1:0] i_INT_A,
  input wire [NI*DW-1:0] i_INT_B,
  input wire [NI-1:0] i_INT_C,
  input wire [NI*3-1:0] i_INT_FWD_A,
  input wire [NI*3-1:0] i_INT_FWD_B,
  input wire [NM-1:0] i_MUL_VLD,
  input wire [NM*4-1:0] i_MUL_OP,
  input wire [NM*DW-1:0] i_MUL_A,
  input wire [NM*DW-1:0] i_MUL_B,
  output wire [NI-1:0] o_BYP_VLD,
  output wire [NI*DW-1:0] o_BYP_RES,
  output wire [NI-1:0] o_BYP_CND,
  output wire [NI-1:0] o_RET_INT_VLD,
  output wire [NI*DW-1:0] o_RET_INT_RES,
  output wire [NI-1:0] o_RET_INT_CND,
  output wire [NM-1:0] o_RET_MUL_VLD,
  output wire [NM*DW-1:0] o_RET_MUL_RES
);

  // ****************************************
  // Bypass network
  // ****************************************
  // Results of the integer lanes one cycle after issue
  reg [NI*DW-1:0] byp_res_q;
  // Condition results one cycle after issue
  reg [NI-1:0] byp_cnd_q;
  // Lane valid one cycle after issue
  reg [NI-1:0] byp_vld_q;

  // Picks the issued operand or a lane's fresh result
  function [DW-1:0] pick;
    input [2:0] sel;
    input [DW-1:0] own;
    input [NI*DW-1:0] byp;
    integer k;
    begin
      pick = own;
      for (k = 0; k < NI; k = k + 1)
      begin
        // Lane k result replaces the stale operand
        if (sel == k[2:0] + 3'h1)
        begin
          pick = byp[k*DW +: DW];
        end
      end
    end
  endfunction

  // ****************************************
  // Integer lanes
  // ****************************************
  // Integer retire delay line, two more stages after the bypass stage
  reg [NI*DW-1:0] int_d1_res_q;
  reg [NI-1:0] int_d1_cnd_q;
  reg [NI-1:0] int_d1_vld_q;
  reg [NI*DW-1:0] int_d2_res_q;
  reg [NI-1:0] int_d2_cnd_q;
  reg [NI-1:0] int_d2_vld_q;

  genvar gi;
  generate
    for (gi = 0; gi < NI; gi = gi + 1)
    begin : g_int
      // Operand after forwarding
      wire [DW-1:0] a = pick(i_INT_FWD_A[gi*3 +: 3], i_INT_A[gi*DW +: DW], byp_res_q);
      wire [DW-1:0] b = pick(i_INT_FWD_B[gi*3 +: 3], i_INT_B[gi*DW +: DW], byp_res_q);
      // Condition operand
      wire c = i_INT_C[gi];
      // Operation code of this lane
      wire [3:0] op = i_INT_OP[gi*4 +: 4];
      // Signed compare helper
      wire lt_s = $signed(a) < $signed(b);
      // Next word and condition results
      reg [DW-1:0] res_d;
      reg cnd_d;

      // Single-cycle operation decode
      always @*
      begin
        res_d = `VIMU_RST_WORD;
        cnd_d = `VIMU_RST_BIT;
        case (op)
          `VIMU_OP_ADD: res_d = a + b;
          `VIMU_OP_SUB: res_d = a - b;
          `VIMU_OP_AND: res_d = a & b;
          `VIMU_OP_OR: res_d = a | b;
          `VIMU_OP_XOR: res_d = a ^ b;
          `VIMU_OP_SHL: res_d = a << b[4:0];
          `VIMU_OP_SHR: res_d = $signed(a) >>> b[4:0];
          `VIMU_OP_SHRU: res_d = a >> b[4:0];
          `VIMU_OP_CMPEQ:
          begin
            // Condition and word both carry the compare
            cnd_d = (a == b);
            res_d = {{(DW-1){1'b0}}, cnd_d};
          end
          `VIMU_OP_CMPLT:
          begin
            cnd_d = lt_s;
            res_d = {{(DW-1){1'b0}}, cnd_d};
          end
          `VIMU_OP_CMPLTU:
          begin
            cnd_d = (a < b);
            res_d = {{(DW-1){1'b0}}, cnd_d};
          end
          `VIMU_OP_SLCT: res_d = c ? a : b;
          `VIMU_OP_MIN: res_d = lt_s ? a : b;
          `VIMU_OP_MAX: res_d = lt_s ? b : a;
          `VIMU_OP_ANDC:
          begin
            // Logical AND of condition with word test
            cnd_d = c & (a != `VIMU_RST_WORD);
            res_d = a & ~b;
          end
          default:
          begin
            // No operation
            res_d = `VIMU_RST_WORD;
            cnd_d = `VIMU_RST_BIT;
          end
        endcase
      end

      // Result register: ready for the very next bundle
      always @(posedge I_CLK or posedge I_RST)
      begin
        if (I_RST)
        begin
          byp_res_q[gi*DW +: DW] <= `VIMU_RST_WORD;
          byp_cnd_q[gi] <= `VIMU_RST_BIT;
          byp_vld_q[gi] <= `VIMU_RST_BIT;
        end
        else
        begin
          // Every lane takes its operation each cycle, no stall path
          byp_res_q[gi*DW +: DW] <= res_d;
          byp_cnd_q[gi] <= cnd_d;
          byp_vld_q[gi] <= i_INT_VLD[gi];
        end
      end
    end
  endgenerate

  // Delay integer results so they retire with the multiplies
  always @(posedge I_CLK or posedge I_RST)
  begin
    if (I_RST)
    begin
      int_d1_res_q <= {NI*DW{1'b0}};
      int_d1_cnd_q <= {NI{1'b0}};
      int_d1_vld_q <= {NI{1'b0}};
      int_d2_res_q <= {NI*DW{1'b0}};
      int_d2_cnd_q <= {NI{1'b0}};
      int_d2_vld_q <= {NI{1'b0}};
    end
    else
    begin
      int_d1_res_q <= byp_res_q;
      int_d1_cnd_q <= byp_cnd_q;
      int_d1_vld_q <= byp_vld_q;
      int_d2_res_q <= int_d1_res_q;
      int_d2_cnd_q <= int_d1_cnd_q;
      int_d2_vld_q <= int_d1_vld_q;
    end
  end

  // ****************************************
  // Multiply lanes
  // ****************************************
  // Stage 1 operand capture
  reg [NM*DW-1:0] m1_a_q;
  reg [NM*DW-1:0] m1_b_q;
  reg [NM*4-1:0] m1_op_q;
  reg [NM-1:0] m1_vld_q;
  // Stage 2 full product
  reg [NM*2*DW-1:0] m2_p_q;
  reg [NM*4-1:0] m2_op_q;
  reg [NM-1:0] m2_vld_q;
  // Stage 3 selected word
  reg [NM*DW-1:0] m3_res_q;
  reg [NM-1:0] m3_vld_q;

  genvar gm;
  generate
    for (gm = 0; gm < NM; gm = gm + 1)
    begin : g_mul
      // Signed high product needs sign extension
      wire sgn = (m1_op_q[gm*4 +: 4] == `VIMU_MOP_MULH);
      wire [DW-1:0] ma = m1_a_q[gm*DW +: DW];
      wire [DW-1:0] mb = m1_b_q[gm*DW +: DW];
      wire [2*DW-1:0] ea = {{DW{sgn & ma[DW-1]}}, ma};
      wire [2*DW-1:0] eb = {{DW{sgn & mb[DW-1]}}, mb};
      // Low double-width bits of the extended product
      wire [2*DW-1:0] prod = ea * eb;
      // Stage 2 product and code
      wire [2*DW-1:0] p2 = m2_p_q[gm*2*DW +: 2*DW];
      wire [3:0] op2 = m2_op_q[gm*4 +: 4];

      // Three pipeline stages, a new operation every cycle
      always @(posedge I_CLK or posedge I_RST)
      begin
        if (I_RST)
        begin
          m1_a_q[gm*DW +: DW] <= `VIMU_RST_WORD;
          m1_b_q[gm*DW +: DW] <= `VIMU_RST_WORD;
          m1_op_q[gm*4 +: 4] <= `VIMU_MOP_MULL;
          m1_vld_q[gm] <= `VIMU_RST_BIT;
          m2_p_q[gm*2*DW +: 2*DW] <= {2*DW{1'b0}};
          m2_op_q[gm*4 +: 4] <= `VIMU_MOP_MULL;
          m2_vld_q[gm] <= `VIMU_RST_BIT;
          m3_res_q[gm*DW +: DW] <= `VIMU_RST_WORD;
          m3_vld_q[gm] <= `VIMU_RST_BIT;
        end
        else
        begin
          // Stage 1 takes the bundle's multiply slot
          m1_a_q[gm*DW +: DW] <= i_MUL_A[gm*DW +: DW];
          m1_b_q[gm*DW +: DW] <= i_MUL_B[gm*DW +: DW];
          m1_op_q[gm*4 +: 4] <= i_MUL_OP[gm*4 +: 4];
          m1_vld_q[gm] <= i_MUL_VLD[gm];
          // Stage 2 forms the product
          m2_p_q[gm*2*DW +: 2*DW] <= prod;
          m2_op_q[gm*4 +: 4] <= m1_op_q[gm*4 +: 4];
          m2_vld_q[gm] <= m1_vld_q[gm];
          // Stage 3 picks the half asked for
          if (op2 == `VIMU_MOP_MULL)
          begin
            m3_res_q[gm*DW +: DW] <= p2[DW-1:0];
          end
          else
          begin
            m3_res_q[gm*DW +: DW] <= p2[2*DW-1:DW];
          end
          m3_vld_q[gm] <= m2_vld_q[gm];
        end
      end
    end
  endgenerate

  // ****************************************
  // Outputs, all straight from flip-flops
  // ****************************************
  // No interlock: the issue side must keep every operation latency
  assign o_BYP_VLD = byp_vld_q;
  assign o_BYP_RES = byp_res_q;
  assign o_BYP_CND = byp_cnd_q;
  assign o_RET_INT_VLD = int_d2_vld_q;
  assign o_RET_INT_RES = int_d2_res_q;
  assign o_RET_INT_CND = int_d2_cnd_q;
  assign o_RET_MUL_VLD = m3_vld_q;
  assign o_RET_MUL_RES = m3_res_q;

endmodule // vimu_datapath

// ### tb/vimu_chk.sv
`timescale 1ns/100ps
`include "vimu_defines.vh"
// ****************************************
// Port checker of the execution datapath
// ****************************************
module vimu_chk #(
  parameter NI = 4,
  parameter NM = 2,
  parameter DW = 32
) (
  input wire I_CLK,
  input wire I_RST,
  input wire [NI-1:0] i_INT_VLD,
  input wire [NI*4-1:0] i_INT_OP,
  input wire [NI*DW-1:0] i_INT_A,
  input wire [NI*DW-1:0] i_INT_B,
  input wire [NI-1:0] i_INT_C,
  input wire [NI*3-1:0] i_INT_FWD_A,
  input wire [NI*3-1:0] i_INT_FWD_B,
  input wire [NM-1:0] i_MUL_VLD,
  input wire [NM*4-1:0] i_MUL_OP,
  input wire [NM*DW-1:0] i_MUL_A,
  input wire [NM*DW-1:0] i_MUL_B,
  input wire [NI-1:0] o_BYP_VLD,
  input wire [NI*DW-1:0] o_BYP_RES,
  input wire [NI-1:0] o_BYP_CND,
  input wire [NI-1:0] o_RET_INT_VLD,
  input wire [NI*DW-1:0] o_RET_INT_RES,
  input wire [NI-1:0] o_RET_INT_CND,
  input wire [NM-1:0] o_RET_MUL_VLD,
  input wire [NM*DW-1:0] o_RET_MUL_RES
);
  // Lane 0 helper values
  wire [31:0] sum0 = i_INT_A[31:0] + i_INT_B[31:0];
  wire [31:0] prod0 = i_MUL_A[31:0] * i_MUL_B[31:0];
  wire [31:0] byp0 = o_BYP_RES[31:0];
  wire [31:0] b0 = i_INT_B[31:0];
  // No operand taken from the bypass on any lane
  wire nofwd = (i_INT_FWD_A == 12'h000) && (i_INT_FWD_B == 12'h000);
  default clocking @(posedge I_CLK); endclocking
  default disable iff (I_RST);
  AST_BYP_VLD: assert property (o_BYP_VLD == $past(i_INT_VLD))
    else $error("bypass valid not one cycle after issue");
  AST_RET_INT_VLD: assert property (o_RET_INT_VLD == $past(i_INT_VLD, 3))
    else $error("integer retire valid not three cycles after issue");
  AST_RET_MUL_VLD: assert property (o_RET_MUL_VLD == $past(i_MUL_VLD, 3))
    else $error("multiply retire valid not three cycles after issue");
  AST_RET_MATCH: assert property (o_BYP_VLD != 4'h0
    |-> ##2 o_RET_INT_RES == $past(o_BYP_RES, 2))
    else $error("retired integer result differs from bypassed one");
  AST_ADD0: assert property (i_INT_OP[3:0] == `VIMU_OP_ADD && nofwd
    |=> byp0 == $past(sum0))
    else $error("lane 0 sum wrong");
  AST_MUL0: assert property (i_MUL_OP[3:0] == `VIMU_MOP_MULL
    |-> ##3 o_RET_MUL_RES[31:0] == $past(prod0, 3))
    else $error("lane 0 low product wrong");
  AST_NOCND: assert property (i_INT_OP[7:4] < `VIMU_OP_SHL |=> !o_BYP_CND[1])
    else $error("condition result set by arithmetic op");
  AST_FWD0: assert property (i_INT_OP[3:0] == `VIMU_OP_ADD && i_INT_FWD_A[2:0] == 3'h1
    && i_INT_FWD_B[2:0] == 3'h0 |=> byp0 == $past(byp0) + $past(b0))
    else $error("forwarded operand not used");
endmodule // vimu_chk

bind vimu_datapath vimu_chk #(.NI(NI), .NM(NM), .DW(DW)) u_chk (
  .I_CLK(I_CLK),
  .I_RST(I_RST),
  .i_INT_VLD(i_INT_VLD),
  .i_INT_OP(i_INT_OP),
  .i_INT_A(i_INT_A),
  .i_INT_B(i_INT_B),
  .i_INT_C(i_INT_C),
  .i_INT_FWD_A(i_INT_FWD_A),
  .i_INT_FWD_B(i_INT_FWD_B),
  .i_MUL_VLD(i_MUL_VLD),
  .i_MUL_OP(i_MUL_OP),
  .i_MUL_A(i_MUL_A),
  .i_MUL_B(i_MUL_B),
  .o_BYP_VLD(o_BYP_VLD),
  .o_BYP_RES(o_BYP_RES),
  .o_BYP_CND(o_BYP_CND),
  .o_RET_INT_VLD(o_RET_INT_VLD),
  .o_RET_INT_RES(o_RET_INT_RES),
  .o_RET_INT_CND(o_RET_INT_CND),
  .o_RET_MUL_VLD(o_RET_MUL_VLD),
  .o_RET_MUL_RES(o_RET_MUL_RES)
);

// ### tb/vimu_rf.sv
`timescale 1ns/100ps
// ****************************************
// Register file write counter at retire
// ****************************************
module vimu_rf (
  input wire i_clk,
  input wire i_rst,
  input wire [3:0] i_int_we,
  input wire [1:0] i_mul_we,
  output wire [15:0] o_wr_cnt
);
  logic [15:0] cnt_q; // Writes seen so far
  assign o_wr_cnt = cnt_q;
  // Every lane of a bundle writes back in the same retire cycle
  always @(posedge i_clk or posedge i_rst)
    if (i_rst)
      cnt_q <= 16'h0000;
    else
      cnt_q <= cnt_q + 16'($countones(i_int_we)) + 16'($countones(i_mul_we));
endmodule // vimu_rf

// ### tb/vimu_datapath_tb.sv
`timescale 1ns/100ps
`include "vimu_defines.vh"
`define CHK(g, x) begin samples_checked++; if ((g) !== (x)) begin n_mismatch++; \
  $display("[FAIL] %0t result mismatch", $time); end end
module vimu_datapath_tb;
  // ****************************************
  // Stimulus, results and bookkeeping
  // ****************************************
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] int_vld = 4'h0;
  logic [3:0] int_c = 4'h0;
  logic [15:0] int_op = 16'h0000;
  logic [127:0] int_a = 128'h0;
  logic [127:0] int_b = 128'h0;
  logic [11:0] fwd_a = 12'h000;
  logic [11:0] fwd_b = 12'h000;
  logic [1:0] mul_vld = 2'h0;
  logic [7:0] mul_op = 8'h00;
  logic [63:0] mul_a = 64'h0;
  logic [63:0] mul_b = 64'h0;
  wire [3:0] byp_vld, byp_cnd, ret_vld, ret_cnd;
  wire [127:0] byp_res, ret_res;
  wire [1:0] rm_vld;
  wire [63:0] rm_res;
  wire [15:0] wr_cnt;
  logic [195:0] exp_q[$]; // Expected retire conditions and words, oldest first
  logic [195:0] cur;
  logic [31:0] prev0; // Lane 0 result of the previous bundle
  bit prev_on = 0;
  int n_mismatch = 0;
  int samples_checked = 0;
  int n_ops = 0;

  always #25 clk = ~clk;

  vimu_datapath i_dut (.I_CLK(clk), .I_RST(rst), .i_INT_VLD(int_vld), .i_INT_OP(int_op),
    .i_INT_A(int_a), .i_INT_B(int_b), .i_INT_C(int_c), .i_INT_FWD_A(fwd_a),
    .i_INT_FWD_B(fwd_b), .i_MUL_VLD(mul_vld), .i_MUL_OP(mul_op), .i_MUL_A(mul_a),
    .i_MUL_B(mul_b), .o_BYP_VLD(byp_vld), .o_BYP_RES(byp_res), .o_BYP_CND(byp_cnd),
    .o_RET_INT_VLD(ret_vld), .o_RET_INT_RES(ret_res), .o_RET_INT_CND(ret_cnd),
    .o_RET_MUL_VLD(rm_vld), .o_RET_MUL_RES(rm_res));
  vimu_rf i_rf (.i_clk(clk), .i_rst(rst), .i_int_we(ret_vld), .i_mul_we(rm_vld),
    .o_wr_cnt(wr_cnt));

  // Expected integer result: condition in bit 32, word below it
  function automatic logic [32:0] model(input logic [3:0] op, input logic [31:0] a,
    input logic [31:0] b, input logic c);
    logic lt;
    lt = $signed(a) < $signed(b);
    case (op)
      `VIMU_OP_ADD: return {1'b0, a + b};
      `VIMU_OP_SUB: return {1'b0, a - b};
      `VIMU_OP_AND: return {1'b0, a & b};
      `VIMU_OP_OR: return {1'b0, a | b};
      `VIMU_OP_XOR: return {1'b0, a ^ b};
      `VIMU_OP_SHL: return {1'b0, a << b[4:0]};
      `VIMU_OP_SHR: return {1'b0, ($signed(a) >>> b[4:0])};
      `VIMU_OP_SHRU: return {1'b0, a >> b[4:0]};
      `VIMU_OP_CMPEQ: return {(a == b), 31'h0, (a == b)};
      `VIMU_OP_CMPLT: return {lt, 31'h0, lt};
      `VIMU_OP_CMPLTU: return {(a < b), 31'h0, (a < b)};
      `VIMU_OP_SLCT: return {1'b0, (c ? a : b)};
      `VIMU_OP_MIN: return {1'b0, (lt ? a : b)};
      `VIMU_OP_MAX: return {1'b0, (lt ? b : a)};
      `VIMU_OP_ANDC: return {(c & (a != 32'h0)), (a & ~b)};
      default: return 33'h0;
    endcase
  endfunction

  // Drives one full bundle, or an idle one, and notes what must retire
  task automatic drive(input bit on);
    logic [31:0] a, b;
    logic [32:0] rc;
    logic [63:0] p;
    logic [3:0] op;
    logic [195:0] e;
    bit fw;
    e = 196'h0;
    fw = prev_on && on && ($urandom % 3 == 0);
    int_c = 4'($urandom);
    for (int k = 0; k < 4; k++)
    begin
      a = $urandom;
      b = $urandom;
      op = (k == 0 && fw) ? `VIMU_OP_ADD : 4'($urandom);
      int_a[32*k+:32] = a;
      int_b[32*k+:32] = b;
      int_op[4*k+:4] = op;
      // Forwarded lane takes the previous lane 0 result instead
      if (k == 0 && fw)
        a = prev0;
      rc = model(op, a, b, int_c[k]);
      e[64+32*k+:32] = rc[31:0];
      e[192+k] = rc[32];
      if (k == 0)
        prev0 = rc[31:0];
    end
    fwd_a = fw ? 12'h001 : 12'h000;
    for (int k = 0; k < 2; k++)
    begin
      a = $urandom;
      b = $urandom;
      op = 4'($urandom % 3);
      mul_a[32*k+:32] = a;
      mul_b[32*k+:32] = b;
      mul_op[4*k+:4] = op;
      // Signed high half needs sign-extended operands
      if (op == `VIMU_MOP_MULH)
        p = {{32{a[31]}}, a} * {{32{b[31]}}, b};
      else
        p = {32'h0, a} * {32'h0, b};
      e[32*k+:32] = (op == `VIMU_MOP_MULL) ? p[31:0] : p[63:32];
    end
    int_vld = on ? 4'hF : 4'h0;
    mul_vld = on ? 2'h3 : 2'h0;
    if (on)
      exp_q.push_back(e);
    prev_on = on;
  endtask

  // Closing report
  task automatic print_verdict;
    if (n_mismatch == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // Compares each retiring bundle with the oldest note
  always @(negedge clk)
    if (!rst && (ret_vld != 4'h0 || rm_vld != 2'h0))
    begin
      cur = (exp_q.size() > 0) ? exp_q.pop_front() : 196'hX;
      `CHK(ret_vld, 4'hF)
      `CHK(rm_vld, 2'h3)
      `CHK(ret_res, cur[191:64])
      `CHK(ret_cnd, cur[195:192])
      `CHK(rm_res, cur[63:0])
    end

  // Main sequence: back-to-back full bundles with occasional gaps
  initial
  begin
    void'($urandom(68519));
    repeat (6) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    for (int i = 0; i < 200; i++)
    begin
      @(negedge clk);
      drive(i % 7 != 6);
      if (i % 7 != 6)
        n_ops += 6;
    end
    @(negedge clk);
    drive(1'b0);
    repeat (5) @(negedge clk);
    `CHK(exp_q.size(), 0)
    `CHK(wr_cnt, 16'(n_ops))
    print_verdict;
  end
endmodule // vimu_datapath_tb
